// ---- design/fsb_pkg.sv ----
// package of constants and types for the receive status and bit rate block
package fsb_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_DIVISOR = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [7:0] OFS_FIFO_CTRL = 8'h0c;
   localparam logic [7:0] OFS_RX_DATA = 8'h10;
   localparam logic [7:0] OFS_RX_COUNT = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_TIMEOUT = 0;
   localparam int BIT_FULL = 1;
   localparam int BIT_PERR = 2;
   localparam int BIT_FERR = 3;
   localparam int FERR_CNT_LSB = 8;
   localparam int PERR_CNT_LSB = 12;
   localparam int PRESCALE_LSB = 0;
   localparam int TRIG_LSB = 6;
   // irq status / mask layout
   localparam int IRQ_FULL = 0;
   localparam int IRQ_TIMEOUT = 1;
   localparam int IRQ_ERROR = 2;
   localparam int IRQ_OVERRUN = 3;
   localparam int IRQ_W = 4;
   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] DIVISOR_RESET = 8'hff;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [1:0] TRIG_RESET = 2'h0;
   // a bit lasts 64 * 2^(2n-1) = 32 * 4^n prescaled divisor periods
   localparam int SUBTICKS_PER_BIT = 32;
   localparam int TIMEOUT_ETU = 15;
   localparam logic [4:0] TRIG_CODE0 = 5'h01;
   localparam logic [4:0] TRIG_CODE1 = 5'h04;
   localparam logic [4:0] TRIG_CODE2 = 5'h08;
   localparam logic [4:0] TRIG_CODE3 = 5'h0e;
   localparam logic [6:0] PRESCALE_CODE0 = 7'h01;
   localparam logic [6:0] PRESCALE_CODE1 = 7'h04;
   localparam logic [6:0] PRESCALE_CODE2 = 7'h10;
   localparam logic [6:0] PRESCALE_CODE3 = 7'h40;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rx_framing_error_flag;
      logic rx_parity_error_flag;
      logic [7:0] data;
   } fsb_rx_entry_t;
endpackage

// ---- design/fsb_rx_status.sv ----
// receive fifo, receive status flags, error counts and bit rate generator
`timescale 1ns/1ps
module fsb_rx_status #(
   parameter int DEPTH = 16,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic standby,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_push,
   input wire fsb_pkg::fsb_rx_entry_t rx_char,
   output logic baud_tick,
   output logic irq
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int PW = $clog2(DEPTH);

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic [4:0] trig_level(input logic [1:0] sel);
      case (sel)
         2'h0: trig_level = fsb_pkg::TRIG_CODE0;
         2'h1: trig_level = fsb_pkg::TRIG_CODE1;
         2'h2: trig_level = fsb_pkg::TRIG_CODE2;
         default: trig_level = fsb_pkg::TRIG_CODE3;
      endcase
   endfunction

   function automatic logic [6:0] prescale_div(input logic [1:0] sel);
      case (sel)
         2'h0: prescale_div = fsb_pkg::PRESCALE_CODE0;
         2'h1: prescale_div = fsb_pkg::PRESCALE_CODE1;
         2'h2: prescale_div = fsb_pkg::PRESCALE_CODE2;
         default: prescale_div = fsb_pkg::PRESCALE_CODE3;
      endcase
   endfunction

   function automatic logic [3:0] sat4(input logic [CW-1:0] v);
      sat4 = (v > CW'(15)) ? 4'hf : v[3:0];
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic clr_all;
   logic [7:0] divisor_q;
   logic [1:0] mode_q;
   logic [1:0] trig_q;
   localparam int IRQ_W_M1 = fsb_pkg::IRQ_W - 1;
   logic [IRQ_W_M1:0] irq_stat_q;
   logic [IRQ_W_M1:0] irq_mask_q;
   fsb_pkg::fsb_rx_entry_t mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [CW-1:0] count_q;
   logic [CW-1:0] perr_cnt_q;
   logic [CW-1:0] ferr_cnt_q;
   logic ferr_q;
   logic perr_q;
   logic full_q;
   logic timeout_q;
   logic full_seen_q;
   logic timeout_seen_q;
   logic [6:0] pre_cnt_q;
   logic [7:0] div_cnt_q;
   logic [4:0] sub_cnt_q;
   logic [3:0] etu_cnt_q;
   logic idle_armed_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   logic baud_tick_q;
   logic setup;
   logic done;
   logic wr_done;
   logic rd_done;
   logic mapped;
   logic do_push;
   logic do_pop;
   logic overrun;
   logic pre_end;
   logic div_end;
   logic full_set;
   logic full_low;
   logic timeout_set;
   logic [4:0] trig;
   fsb_pkg::fsb_rx_entry_t head;
   logic [15:0] status_word;

   assign clr_all = srst | standby;
   assign setup = psel & ~penable;
   assign done = psel & penable & pready_q;
   assign wr_done = done & pwrite & ~pslverr_q;
   assign rd_done = done & ~pwrite & ~pslverr_q;
   assign trig = trig_level(trig_q);
   assign head = mem_q[rd_ptr_q];
   assign do_push = rx_push & (count_q != CW'(DEPTH));
   assign overrun = rx_push & (count_q == CW'(DEPTH));
   // popping an empty fifo returns whatever the head slot holds
   assign do_pop = rd_done & (paddr == fsb_pkg::OFS_RX_DATA) & (count_q != '0);
   assign mapped = (paddr == fsb_pkg::OFS_STATUS) | (paddr == fsb_pkg::OFS_DIVISOR) |
                   (paddr == fsb_pkg::OFS_MODE) | (paddr == fsb_pkg::OFS_FIFO_CTRL) |
                   (paddr == fsb_pkg::OFS_RX_DATA) | (paddr == fsb_pkg::OFS_RX_COUNT) |
                   (paddr == fsb_pkg::OFS_IRQ_STATUS) | (paddr == fsb_pkg::OFS_IRQ_MASK);

   assign status_word = {sat4(perr_cnt_q), sat4(ferr_cnt_q), 4'h0,
                         ferr_q, perr_q, full_q, timeout_q};

   // ----------------------------------------------------------------
   // apb slave: one wait-free access phase, data prepared in setup
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= setup;
         if (setup) begin
            pslverr_q <= ~mapped;
            prdata_q <= 32'h0;
            if (!pwrite) begin
               case (paddr)
                  fsb_pkg::OFS_STATUS: prdata_q <= {16'h0, status_word};
                  fsb_pkg::OFS_DIVISOR: prdata_q <= {24'h0, divisor_q};
                  fsb_pkg::OFS_MODE: prdata_q <= {30'h0, mode_q};
                  fsb_pkg::OFS_FIFO_CTRL: prdata_q <= {24'h0, trig_q, 6'h0};
                  fsb_pkg::OFS_RX_DATA: prdata_q <= {24'h0, head.data};
                  fsb_pkg::OFS_RX_COUNT: prdata_q <= {{(32-CW){1'b0}}, count_q};
                  fsb_pkg::OFS_IRQ_STATUS: prdata_q <= {{(32-fsb_pkg::IRQ_W){1'b0}}, irq_stat_q};
                  fsb_pkg::OFS_IRQ_MASK: prdata_q <= {{(32-fsb_pkg::IRQ_W){1'b0}}, irq_mask_q};
                  default: prdata_q <= 32'h0;
               endcase
            end
         end else if (done) begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (clr_all) begin
         divisor_q <= fsb_pkg::DIVISOR_RESET;
         mode_q <= fsb_pkg::MODE_RESET;
         trig_q <= fsb_pkg::TRIG_RESET;
         irq_mask_q <= '0;
      end else if (wr_done && pstrb[0]) begin
         case (paddr)
            fsb_pkg::OFS_DIVISOR: divisor_q <= pwdata[7:0];
            fsb_pkg::OFS_MODE: mode_q <= pwdata[fsb_pkg::PRESCALE_LSB +: 2];
            fsb_pkg::OFS_FIFO_CTRL: trig_q <= pwdata[fsb_pkg::TRIG_LSB +: 2];
            fsb_pkg::OFS_IRQ_MASK: irq_mask_q <= pwdata[IRQ_W_M1:0];
            default: divisor_q <= divisor_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // receive fifo and per-fifo error counts
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_q[wr_ptr_q] <= rx_char;
      end
   end

   always_ff @(posedge clk) begin
      if (clr_all) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_q <= wr_ptr_q + PW'(1);
         end
         if (do_pop) begin
            rd_ptr_q <= rd_ptr_q + PW'(1);
         end
         count_q <= count_q + CW'(do_push) - CW'(do_pop);
      end
   end

   // counts track stored entries; the field shows at most 15
   always_ff @(posedge clk) begin
      if (clr_all) begin
         perr_cnt_q <= '0;
         ferr_cnt_q <= '0;
      end else begin
         perr_cnt_q <= perr_cnt_q + CW'(do_push & rx_char.rx_parity_error_flag) - CW'(do_pop & head.rx_parity_error_flag);
         ferr_cnt_q <= ferr_cnt_q + CW'(do_push & rx_char.rx_framing_error_flag) - CW'(do_pop & head.rx_framing_error_flag);
      end
   end

   // error bits mirror the head entry and are never written
   always_ff @(posedge clk) begin
      if (clr_all) begin
         ferr_q <= 1'b0;
         perr_q <= 1'b0;
      end else begin
         ferr_q <= (count_q != '0) & head.rx_framing_error_flag;
         perr_q <= (count_q != '0) & head.rx_parity_error_flag;
      end
   end

   // ----------------------------------------------------------------
   // bit rate generator
   // ----------------------------------------------------------------
   assign pre_end = (pre_cnt_q == prescale_div(mode_q) - 7'h1) ||
                    (pre_cnt_q >= prescale_div(mode_q));
   assign div_end = pre_end & (div_cnt_q == 8'h0);

   always_ff @(posedge clk) begin
      if (clr_all) begin
         pre_cnt_q <= '0;
         div_cnt_q <= fsb_pkg::DIVISOR_RESET;
         sub_cnt_q <= '0;
         baud_tick_q <= 1'b0;
      end else begin
         baud_tick_q <= 1'b0;
         pre_cnt_q <= pre_end ? 7'h0 : pre_cnt_q + 7'h1;
         if (pre_end) begin
            // reload only at period end, so a divisor write never cuts a period short
            div_cnt_q <= (div_cnt_q == 8'h0) ? divisor_q : div_cnt_q - 8'h1;
         end
         if (div_end) begin
            if (sub_cnt_q == 5'(fsb_pkg::SUBTICKS_PER_BIT - 1)) begin
               sub_cnt_q <= '0;
               baud_tick_q <= 1'b1;
            end else begin
               sub_cnt_q <= sub_cnt_q + 5'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // idle timeout, counted in bit periods since the last stop bit
   // ----------------------------------------------------------------
   assign timeout_set = idle_armed_q & baud_tick_q & ~rx_push &
                        (etu_cnt_q == 4'(fsb_pkg::TIMEOUT_ETU - 1)) &
                        (count_q != '0) & (32'(count_q) < 32'(trig));

   always_ff @(posedge clk) begin
      if (clr_all) begin
         etu_cnt_q <= '0;
         idle_armed_q <= 1'b0;
      end else if (rx_push) begin
         etu_cnt_q <= '0;
         idle_armed_q <= 1'b1;
      end else if (baud_tick_q && idle_armed_q) begin
         etu_cnt_q <= etu_cnt_q + 4'h1;
         if (etu_cnt_q == 4'(fsb_pkg::TIMEOUT_ETU - 1)) begin
            idle_armed_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // clearable status flags
   // ----------------------------------------------------------------
   assign full_set = (32'(count_q) > 32'(trig));
   // draining down to the trigger is not enough: the fifo must sit below it
   assign full_low = (32'(count_q) < 32'(trig));

   always_ff @(posedge clk) begin
      if (clr_all) begin
         full_q <= 1'b0;
         timeout_q <= 1'b0;
         full_seen_q <= 1'b0;
         timeout_seen_q <= 1'b0;
      end else begin
         if (rd_done && paddr == fsb_pkg::OFS_STATUS) begin
            full_seen_q <= full_q;
            timeout_seen_q <= timeout_q;
         end
         // set wins over a clear in the same cycle
         if (full_set) begin
            full_q <= 1'b1;
         end else if (wr_done && pstrb[0] && paddr == fsb_pkg::OFS_STATUS &&
                      !pwdata[fsb_pkg::BIT_FULL] && full_seen_q && full_low) begin
            full_q <= 1'b0;
            full_seen_q <= 1'b0;
         end
         if (timeout_set) begin
            timeout_q <= 1'b1;
         end else if (wr_done && pstrb[0] && paddr == fsb_pkg::OFS_STATUS &&
                      !pwdata[fsb_pkg::BIT_TIMEOUT] && timeout_seen_q) begin
            timeout_q <= 1'b0;
            timeout_seen_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, write one to clear, and masked output
   // ----------------------------------------------------------------
   logic [IRQ_W_M1:0] irq_evt;
   always_comb begin
      irq_evt = '0;
      irq_evt[fsb_pkg::IRQ_FULL] = full_set & ~full_q;
      irq_evt[fsb_pkg::IRQ_TIMEOUT] = timeout_set;
      irq_evt[fsb_pkg::IRQ_ERROR] = do_push & (rx_char.rx_framing_error_flag | rx_char.rx_parity_error_flag);
      irq_evt[fsb_pkg::IRQ_OVERRUN] = overrun;
   end

   always_ff @(posedge clk) begin
      if (clr_all) begin
         irq_stat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         if (wr_done && pstrb[0] && paddr == fsb_pkg::OFS_IRQ_STATUS) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W_M1:0]) | irq_evt;
         end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
         end
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign baud_tick = baud_tick_q;
   assign irq = irq_q;
endmodule

// ---- testbench/fsb_line_model.sv ----
// behavioural far-end transceiver that hands finished characters to the block
`timescale 1ns/1ps
module fsb_line_model (
   input wire logic clk,
   output logic rx_push,
   output fsb_pkg::fsb_rx_entry_t rx_char
);
   initial begin
      rx_push = 1'b0;
      rx_char = '0;
   end
   // outside a push the character is not valid, so it shows the inverse of the last one
   task automatic send(input fsb_pkg::fsb_rx_entry_t e, input int gap);
      begin
         rx_push <= 1'b1;
         rx_char <= e;
         @(posedge clk);
         rx_push <= 1'b0;
         rx_char <= ~e;
         repeat (gap + 1) @(posedge clk);
      end
   endtask
endmodule

// ---- testbench/fsb_rx_status_checker.sv ----
// concurrent checks on the ports of the receive status and bit rate block
`timescale 1ns/1ps
module fsb_rx_status_checker #(
   parameter int DEPTH = 16,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic standby,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rx_push,
   input wire fsb_pkg::fsb_rx_entry_t rx_char,
   input wire logic baud_tick,
   input wire logic irq
);
   logic [7:0] div_q;
   logic [1:0] mode_q;
   logic [19:0] cnt_q;
   logic chg_q;
   logic chg2_q;
   logic [19:0] per_w;
   logic wr_acc;
   logic rd_acc;
   assign wr_acc = psel && penable && pready && pwrite && pstrb[0];
   assign rd_acc = psel && penable && pready && !pwrite;
   assign per_w = 20'(div_q + 9'h1) << (5 + 2 * mode_q);
   // ----------------------------------------------------------------
   // shadow of divisor and prescale, and the spacing of ticks
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst || standby) begin
         div_q <= 8'hff;
         mode_q <= 2'h0;
      end else if (wr_acc && paddr == fsb_pkg::OFS_DIVISOR) begin
         div_q <= pwdata[7:0];
      end else if (wr_acc && paddr == fsb_pkg::OFS_MODE) begin
         mode_q <= pwdata[1:0];
      end
   end
   // a period that saw a setting change is not judged: the reload point is ambiguous
   always_ff @(posedge clk) begin
      if (srst || standby) begin
         cnt_q <= 20'h0;
         chg_q <= 1'b1;
         chg2_q <= 1'b1;
      end else begin
         cnt_q <= baud_tick ? 20'h1 : cnt_q + 20'h1;
         if (baud_tick) begin
            chg2_q <= chg_q;
         end
         if (wr_acc && (paddr == fsb_pkg::OFS_DIVISOR || paddr == fsb_pkg::OFS_MODE)) begin
            chg_q <= 1'b1;
         end else if (baud_tick) begin
            chg_q <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_tick_spacing: assert property (
      baud_tick && !chg_q && !chg2_q |-> cnt_q == per_w) else $error("bit period wrong");
   a_tick_pulse: assert property (baud_tick |=> !baud_tick) else $error("tick too long");
   a_div_readback: assert property (
      rd_acc && paddr == fsb_pkg::OFS_DIVISOR |-> prdata == {24'h0, div_q})
      else $error("divisor readback wrong");
   a_mode_readback: assert property (
      rd_acc && paddr == fsb_pkg::OFS_MODE |-> prdata[1:0] == mode_q)
      else $error("prescale readback wrong");
   a_count_bound: assert property (
      rd_acc && paddr == fsb_pkg::OFS_RX_COUNT |-> prdata <= 32'h10)
      else $error("fill count above depth");
   a_status_unused: assert property (
      rd_acc && paddr == fsb_pkg::OFS_STATUS |-> prdata[31:16] == 16'h0 && prdata[7:4] == 4'h0)
      else $error("status spare bits set");
   a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not one cycle after setup");
   a_ready_idle: assert property (!psel |=> !pready) else $error("ready without select");
   a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_standby_quiet: assert property (
      standby |=> !pready && !baud_tick && !irq) else $error("outputs active in standby");
   c_tick: cover property (baud_tick && !chg_q && !chg2_q);
   c_err: cover property (pslverr);
   c_full: cover property (rd_acc && paddr == fsb_pkg::OFS_STATUS && prdata[1]);
endmodule
bind fsb_rx_status fsb_rx_status_checker #(.DEPTH(DEPTH), .AW(AW)) fsb_rx_status_checker_i (
   .clk(clk), .srst(srst), .standby(standby), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rx_push(rx_push), .rx_char(rx_char),
   .baud_tick(baud_tick), .irq(irq));

// ---- testbench/testbench.sv ----
// self-checking bench for the receive status and bit rate block
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [7:0] div;
      logic [1:0] mode;
   } fsb_baud_row_t;
   localparam fsb_baud_row_t ROWS [6] = '{'{8'h01, 2'h0}, '{8'h00, 2'h1}, '{8'h02, 2'h1},
      '{8'h00, 2'h2}, '{8'h00, 2'h3}, '{8'h00, 2'h0}};
   localparam fsb_pkg::fsb_rx_entry_t ENT [5] = '{10'h2e0, 10'h1e1, 10'h3e2, 10'h0e3, 10'h0e4};
   logic clk, srst, standby, psel, penable, pwrite, pready, pslverr, rx_push, baud_tick, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [3:0] pstrb;
   logic ev;
   fsb_pkg::fsb_rx_entry_t rx_char;
   int mismatches, n_compared, n;
   fsb_rx_status fsb_rx_status_i (.clk(clk), .srst(srst), .standby(standby), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_push(rx_push),
      .rx_char(rx_char), .baud_tick(baud_tick), .irq(irq));
   fsb_line_model fsb_line_model_i (.clk(clk), .rx_push(rx_push), .rx_char(rx_char));
   always #2 clk = ~clk;
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // ready is sampled at the rising edge; data is taken and the request dropped at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         mismatches++;
         end_of_test();
      end
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rv, e);
   endtask
   task automatic wait_tick(output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (baud_tick !== 1'b1 && c < 20000);
      if (baud_tick !== 1'b1) begin
         mismatches++;
         end_of_test();
      end
   endtask
   task automatic irq_is(input logic e);
      @(posedge clk);
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      srst = 1'b1;
      standby = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      mismatches = 0;
      n_compared = 0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, fsb_pkg::OFS_DIVISOR, {24'h0, ROWS[i].div});
         apb(1'b1, fsb_pkg::OFS_MODE, {30'h0, ROWS[i].mode});
         repeat (3) wait_tick(n);
         chk("bit period", 32'(n), 32'(32 * (1 << (2 * ROWS[i].mode)) * (ROWS[i].div + 1)));
         rd(fsb_pkg::OFS_DIVISOR, {24'h0, ROWS[i].div}, "divisor");
         rd(fsb_pkg::OFS_MODE, {30'h0, ROWS[i].mode}, "prescale");
      end
      $display("test bit rate done");
      apb(1'b1, fsb_pkg::OFS_FIFO_CTRL, 32'h40);
      for (int i = 0; i < 5; i++) fsb_line_model_i.send(ENT[i], 0);
      rd(fsb_pkg::OFS_STATUS, 32'h220a, "status");
      rd(fsb_pkg::OFS_RX_COUNT, 32'h5, "rx count");
      rd(fsb_pkg::OFS_IRQ_STATUS, 32'h5, "irq status");
      irq_is(1'b0);
      apb(1'b1, fsb_pkg::OFS_STATUS, 32'h0);
      rd(fsb_pkg::OFS_STATUS, 32'h220a, "status");
      rd(fsb_pkg::OFS_RX_DATA, 32'he0, "rx data");
      rd(fsb_pkg::OFS_STATUS, 32'h2106, "status");
      rd(fsb_pkg::OFS_RX_DATA, 32'he1, "rx data");
      rd(fsb_pkg::OFS_RX_DATA, 32'he2, "rx data");
      rd(fsb_pkg::OFS_STATUS, 32'h2, "status");
      apb(1'b1, fsb_pkg::OFS_STATUS, 32'hd);
      rd(fsb_pkg::OFS_STATUS, 32'h0, "status");
      repeat (16) wait_tick(n);
      apb(1'b1, fsb_pkg::OFS_STATUS, 32'h0);
      rd(fsb_pkg::OFS_STATUS, 32'h1, "status");
      apb(1'b1, fsb_pkg::OFS_STATUS, 32'h0);
      rd(fsb_pkg::OFS_STATUS, 32'h0, "status");
      apb(1'b1, fsb_pkg::OFS_IRQ_MASK, 32'h2);
      irq_is(1'b1);
      apb(1'b1, fsb_pkg::OFS_IRQ_STATUS, 32'h2);
      irq_is(1'b0);
      rd(fsb_pkg::OFS_IRQ_STATUS, 32'h5, "irq status");
      $display("test flags done");
      for (int i = 0; i < 15; i++) fsb_line_model_i.send({2'b00, 8'(8'h10 + i)}, i % 2);
      rd(fsb_pkg::OFS_RX_COUNT, 32'h10, "rx count");
      rd(fsb_pkg::OFS_IRQ_STATUS, 32'hd, "irq status");
      apb(1'b1, fsb_pkg::OFS_IRQ_MASK, 32'h8);
      irq_is(1'b1);
      rd(fsb_pkg::OFS_RX_DATA, 32'he3, "rx data");
      rd(fsb_pkg::OFS_RX_DATA, 32'he4, "rx data");
      for (int i = 0; i < 14; i++) rd(fsb_pkg::OFS_RX_DATA, 32'(8'h10 + i), "rx data");
      rd(fsb_pkg::OFS_RX_COUNT, 32'h0, "rx count");
      apb(1'b0, 8'h20, 32'h0);
      chk("slave error", {31'h0, ev}, 32'h1);
      $display("test fill done");
      apb(1'b1, fsb_pkg::OFS_DIVISOR, 32'h5a);
      pstrb <= 4'he;
      apb(1'b1, fsb_pkg::OFS_DIVISOR, 32'h33);
      pstrb <= 4'hf;
      rd(fsb_pkg::OFS_DIVISOR, 32'h5a, "divisor");
      standby <= 1'b1;
      repeat (2) @(posedge clk);
      standby <= 1'b0;
      @(posedge clk);
      rd(fsb_pkg::OFS_DIVISOR, 32'hff, "divisor");
      rd(fsb_pkg::OFS_STATUS, 32'h0, "status");
      rd(fsb_pkg::OFS_FIFO_CTRL, 32'h0, "fifo control");
      rd(fsb_pkg::OFS_RX_COUNT, 32'h0, "rx count");
      fsb_line_model_i.send(ENT[3], 0);
      rd(fsb_pkg::OFS_STATUS, 32'h0, "status");
      fsb_line_model_i.send(ENT[4], 0);
      rd(fsb_pkg::OFS_STATUS, 32'h2, "status");
      rd(fsb_pkg::OFS_RX_DATA, 32'he3, "rx data");
      apb(1'b1, fsb_pkg::OFS_STATUS, 32'h0);
      rd(fsb_pkg::OFS_STATUS, 32'h2, "status");
      rd(fsb_pkg::OFS_RX_DATA, 32'he4, "rx data");
      apb(1'b1, fsb_pkg::OFS_STATUS, 32'h0);
      rd(fsb_pkg::OFS_STATUS, 32'h0, "status");
      $display("test standby done");
      end_of_test();
   end
endmodule
